// ==== rtl/cwd_pkg.sv ====
package cwd_pkg;
  // Overview of operation
  // - Radio: start a word only after four one bits
  // - Source sends zeros until preamble and word
  // - Power decoder when in-lock appears
  // - Unpower on lost lock or, in radio mode only, missing next command
  // - Clear registers and counters at power-up; the code clears all of them only at reset
  // - Radio: shift 63 bits, one per bit clock
  // - Radio: correct single errors, cyclic 63/57 code
  // - Two end-around passes, gate A then B
  // - Correction and output shifting on 10 kHz
  // - Hardline: load 43 bits, skip correction
  // - Decode register bits one to forty-three
  // - Quantitative: pulse out bits 12-43, left first
  // - Direct command drives a holding latch
  // - Negative integrator sample is one, positive zero
  // - Source bit period is one second
  // - Lock detector dumps each bit, flags weak agreement
  // - Frequency counter gated, dumped by shift pulses
  // - Test mode feeds stored word, radio lock guaranteed
  // - Source sync slips until phases line up
  // - Interface pulses last ten microseconds

  // word layout: bit n of the command sits at index 63 - n
  localparam int WORD_BITS = 63;
  localparam int HARD_BITS = 43;
  localparam int PREAMBLE_BITS = 4;
  localparam int QUANT_BITS = 32;
  localparam int ID_MSB = 62;
  localparam int ID_LSB = 52;
  localparam int QUANT_MSB = 51;
  localparam logic [5:0] RADIO_LAST = 6'(WORD_BITS - 1);
  localparam logic [5:0] HARD_LAST = 6'(HARD_BITS - 1);
  localparam logic [5:0] QUANT_LAST = 6'(QUANT_BITS - 1);
  localparam logic [5:0] PRE_LAST = 6'(PREAMBLE_BITS - 1);
  // command identifier fields
  localparam int ID_QUANT_BIT = 10;
  localparam int ID_SET_BIT = 4;
  localparam int SEL_W = 4;
  localparam int DIRECT_N = 16;
  localparam int DEST_W = 10;
  // cyclic code: x^6 = x + 1, and x^-1 = x^5 + 1
  localparam logic [5:0] GEN_LOW = 6'h03;
  localparam logic [5:0] SYN_HIT = 6'h21;
  // detector samples and lock decision
  localparam int SAMPLE_W = 8;
  localparam int ACC_W = 40;
  localparam logic signed [ACC_W-1:0] LOCK_MIN = 40'sh00_0000_0000;
  localparam logic signed [SAMPLE_W-1:0] INTEG_MAG = 8'sh40;
  localparam logic signed [SAMPLE_W-1:0] PHASE_MAG = 8'sh20;
  localparam logic [3:0] GAP_BITS = 4'h8;
  // timing
  localparam int SYS_PERIOD_NS = 5;
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int SHIFT_CLK_HZ = 10_000;
  localparam int TICK_CYC_DEF = SYS_CLK_HZ / SHIFT_CLK_HZ;
  localparam int TICK_W = 16;
  localparam int PULSE_NS = 10_000;
  localparam int PULSE_CYC = (PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int PULSE_W = 12;
  localparam int LINK_DIV = 3;
  localparam int LINK_PERIOD_NS = SYS_PERIOD_NS * LINK_DIV;
  localparam int PULSE_LINK_CLKS = (PULSE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int BIT_PERIOD_MS = 1000;
  localparam int BIT_LINK_CLKS_DEF = BIT_PERIOD_MS * 1_000_000 / LINK_PERIOD_NS;
  localparam int SYNC_SLIP_DEF = 1;
  localparam int VCO_W = 16;
endpackage

// ==== rtl/cwd_link_if.sv ====
interface cwd_link_if;
  // bit-rate link, all fields but hardline change on the falling edge of link_clk; hardline changes when the source takes a command
  logic link_clk;
  logic bit_end;
  logic signed [cwd_pkg::SAMPLE_W-1:0] integ_sample;
  logic signed [cwd_pkg::SAMPLE_W-1:0] phase_sample;
  logic sc_lock;
  logic hardline;
  logic word_sync;

  modport device (
    input link_clk, bit_end, integ_sample, phase_sample, sc_lock, hardline, word_sync
  );
  modport source (
    output link_clk, bit_end, integ_sample, phase_sample, sc_lock, hardline, word_sync
  );
endinterface

// ==== rtl/cwd_decoder.sv ====
module cwd_decoder #(
  parameter int TICK_CYC = cwd_pkg::TICK_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link from the detector or hardline decoder
  cwd_link_if.device link,
  // test sequencer
  input wire logic test_active,
  input wire logic test_bit,
  // telemetry frequency counter
  input wire logic vco_tick,
  input wire logic count_gate_start,
  input wire logic count_gate_stop,
  input wire logic frequency_count_shift_pulses,
  output logic vco_count_bit,
  // command outputs
  output logic decoder_power,
  output logic [cwd_pkg::DIRECT_N-1:0] direct_command,
  output logic [cwd_pkg::DEST_W-1:0] quantitative_command,
  output logic quant_pulse_one,
  output logic quant_pulse_zero,
  output logic command_done
);
  import cwd_pkg::*;

  typedef enum logic [1:0] {L_HUNT, L_LOAD, L_HAND, L_GAP} cwd_lstate_type;
  typedef enum logic [2:0] {S_IDLE, S_PASS1, S_PASS2, S_DECODE, S_QUANT} cwd_sstate_type;

  // link-side state, clocked by the detector bit clock
  typedef struct packed {
    cwd_lstate_type st;
    logic power;
    logic lock;
    logic lock_prev;
    logic signed [ACC_W-1:0] acc;
    logic [3:0] hist;
    logic [5:0] cnt;
    logic [3:0] gap;
    logic [WORD_BITS-1:0] word;
    logic hard;
    logic req;
    logic [1:0] ack_s;
    logic [1:0] tact_s;
    logic [1:0] tbit_s;
  } cwd_link_type;

  // system-side state, clocked by clk_sys
  typedef struct packed {
    cwd_sstate_type st;
    logic [2:0] req_s;
    logic [1:0] pw_s;
    logic ack;
    logic [WORD_BITS-1:0] word;
    logic [5:0] syn;
    logic [5:0] cnt;
    logic [TICK_W-1:0] tick;
    logic [PULSE_W-1:0] pulse;
    logic q1;
    logic q0;
    logic [DIRECT_N-1:0] direct;
    logic [DEST_W-1:0] dest;
    logic done;
    logic [2:0] vs;
    logic [2:0] ctl_prev;
    logic gate_on;
    logic [VCO_W-1:0] vcnt;
    logic [VCO_W-1:0] vsh;
    logic vbit;
  } cwd_sys_type;

  cwd_link_type lq, ln;
  cwd_sys_type sq, sn;

  logic test_mode;
  logic bit_val;
  logic lock_ok;
  logic [3:0] hist_next;
  logic signed [ACC_W-1:0] acc_sum;
  logic tick;
  logic req_edge;
  logic [ID_MSB-ID_LSB:0] cmd_id;
  logic [2:0] ctl_now;
  logic [2:0] ctl_rise;

  // test mode comes from the sequencer clock domain, so it is resynchronised first
  // stored test word
  assign test_mode = lq.tact_s[1];
  assign bit_val = test_mode ? lq.tbit_s[1] : link.integ_sample[SAMPLE_W-1];
  assign hist_next = {lq.hist[2:0], bit_val};
  assign acc_sum = lq.acc + ACC_W'(link.phase_sample);
  assign lock_ok = link.hardline ? link.sc_lock : (lq.lock & (link.sc_lock | test_mode));

  // link-side sequencing: lock, preamble hunt, loading, hand-over
  always_comb begin
    ln = lq;
    ln.ack_s = {lq.ack_s[0], sq.ack};
    ln.tact_s = {lq.tact_s[0], test_active};
    ln.tbit_s = {lq.tbit_s[0], test_bit};
    ln.lock_prev = lock_ok;
    if (link.bit_end) begin
      ln.acc = '0;
      ln.lock = test_mode | (acc_sum > LOCK_MIN);
      ln.hist = hist_next;
    end else begin
      ln.acc = acc_sum;
    end
    if (lock_ok && !lq.lock_prev) begin
      ln.power = 1'b1;
    end
    unique case (lq.st)
      L_HUNT, L_GAP: begin
        if (link.hardline) begin
          if (link.word_sync && lock_ok) begin
            ln.st = L_LOAD;
            ln.power = 1'b1;
            ln.word = '0;
            ln.cnt = '0;
            ln.gap = '0;
            ln.hard = 1'b1;
          end
        end else if (link.bit_end && hist_next == 4'hf && lock_ok) begin
          ln.st = L_LOAD;
          ln.power = 1'b1;
          ln.word = '0;
          ln.cnt = '0;
          ln.gap = '0;
          ln.hist = '0;
          ln.hard = 1'b0;
        end else if (lq.st == L_GAP && link.bit_end) begin
          ln.gap = lq.gap + 4'h1;
          if (lq.gap == GAP_BITS - 4'h1) begin
            ln.st = L_HUNT;
            ln.power = 1'b0;
          end
        end
      end
      L_LOAD: begin
        if (link.bit_end) begin
          ln.word[ID_MSB - int'(lq.cnt)] = bit_val;
          ln.cnt = lq.cnt + 6'h1;
          if (lq.cnt == (lq.hard ? HARD_LAST : RADIO_LAST)) begin
            ln.st = L_HAND;
            ln.req = ~lq.req;
          end
        end
      end
      L_HAND: begin
        // word stays frozen until the system side acknowledges it, after decoding or as the last quantitative pulse starts
        if (lq.ack_s[1] == lq.req) begin
          ln.st = lq.power ? L_GAP : L_HUNT;
          ln.gap = '0;
          ln.hist = '0;
        end
      end
    endcase
    if (!lock_ok && (lq.lock_prev || lq.st != L_HUNT)) begin
      ln.power = 1'b0;
      if (lq.st != L_HAND) begin
        ln.st = L_HUNT;
      end
    end
  end

  always_ff @(posedge link.link_clk or posedge reset) begin
    if (reset) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  assign tick = (sq.tick == TICK_W'(TICK_CYC - 1));
  assign req_edge = sq.req_s[2] ^ sq.req_s[1];
  assign cmd_id = sq.word[ID_MSB:ID_LSB];
  assign ctl_now = {count_gate_start, count_gate_stop, frequency_count_shift_pulses};
  assign ctl_rise = ctl_now & ~sq.ctl_prev;

  // system side: correction, decoding, outputs and telemetry counter
  always_comb begin
    sn = sq;
    sn.done = 1'b0;
    sn.req_s = {sq.req_s[1:0], lq.req};
    sn.pw_s = {sq.pw_s[0], lq.power};
    sn.tick = tick ? '0 : sq.tick + TICK_W'(1);
    if (sq.pulse != '0) begin
      sn.pulse = sq.pulse - PULSE_W'(1);
    end else begin
      sn.q1 = 1'b0;
      sn.q0 = 1'b0;
    end
    unique case (sq.st)
      S_IDLE: begin
        if (req_edge) begin
          // the link word is stable while its request is outstanding
          sn.word = lq.word;
          sn.syn = '0;
          sn.cnt = '0;
          if (!sq.pw_s[1]) begin
            sn.ack = sq.req_s[1];
          end else if (lq.hard) begin
            sn.st = S_DECODE;
          end else begin
            sn.st = S_PASS1;
          end
        end
      end
      S_PASS1: begin
        if (tick) begin
          sn.word = {sq.word[WORD_BITS-2:0], sq.word[WORD_BITS-1]};
          sn.syn = {sq.syn[4:0], sq.word[WORD_BITS-1]} ^ (sq.syn[5] ? GEN_LOW : 6'h00);
          sn.cnt = sq.cnt + 6'h1;
          if (sq.cnt == RADIO_LAST) begin
            sn.st = S_PASS2;
            sn.cnt = '0;
          end
        end
      end
      S_PASS2: begin
        if (tick) begin
          sn.word = {sq.word[WORD_BITS-2:0], sq.word[WORD_BITS-1] ^ (sq.syn == SYN_HIT)};
          sn.syn = {sq.syn[4:0], 1'b0} ^ (sq.syn[5] ? GEN_LOW : 6'h00);
          sn.cnt = sq.cnt + 6'h1;
          if (sq.cnt == RADIO_LAST) begin
            sn.st = S_DECODE;
            sn.cnt = '0;
          end
        end
      end
      S_DECODE: begin
        if (cmd_id[ID_QUANT_BIT]) begin
          sn.dest = cmd_id[DEST_W-1:0];
          sn.st = S_QUANT;
        end else begin
          sn.direct[cmd_id[SEL_W-1:0]] = cmd_id[ID_SET_BIT];
          sn.done = 1'b1;
          sn.ack = sq.req_s[1];
          sn.st = S_IDLE;
        end
      end
      S_QUANT: begin
        if (tick) begin
          sn.q1 = sq.word[QUANT_MSB - int'(sq.cnt)];
          sn.q0 = ~sq.word[QUANT_MSB - int'(sq.cnt)];
          sn.pulse = PULSE_W'(PULSE_CYC - 1);
          sn.cnt = sq.cnt + 6'h1;
          if (sq.cnt == QUANT_LAST) begin
            sn.done = 1'b1;
            sn.ack = sq.req_s[1];
            sn.st = S_IDLE;
          end
        end
      end
      default: begin
        sn.st = S_IDLE;
      end
    endcase
    // losing power abandons the word but still releases the link side
    if (!sq.pw_s[1] && sq.st != S_IDLE) begin
      sn.st = S_IDLE;
      sn.ack = sq.req_s[1];
    end
    sn.vs = {sq.vs[1:0], vco_tick};
    sn.ctl_prev = ctl_now;
    if (ctl_rise[2]) begin
      sn.gate_on = 1'b1;
      sn.vcnt = '0;
    end else if (sq.gate_on && sq.vs[1] && !sq.vs[2]) begin
      sn.vcnt = sq.vcnt + VCO_W'(1);
    end
    if (ctl_rise[1]) begin
      sn.gate_on = 1'b0;
      sn.vsh = sq.vcnt;
    end else if (ctl_rise[0]) begin
      sn.vbit = sq.vsh[VCO_W-1];
      sn.vsh = {sq.vsh[VCO_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sq <= '0;
    end else begin
      sq <= sn;
    end
  end

  // outputs straight from registers
  assign decoder_power = sq.pw_s[1];
  assign direct_command = sq.direct;
  assign quantitative_command = sq.dest;
  assign quant_pulse_one = sq.q1;
  assign quant_pulse_zero = sq.q0;
  assign command_done = sq.done;
  assign vco_count_bit = sq.vbit;
endmodule

// ==== rtl/cwd_command_source.sv ====
module cwd_command_source #(
  parameter int BIT_LINK_CLKS = cwd_pkg::BIT_LINK_CLKS_DEF,
  parameter int SYNC_SLIP = cwd_pkg::SYNC_SLIP_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link toward the decoder
  cwd_link_if.source link,
  // command request
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [cwd_pkg::WORD_BITS-1:0] send_word,
  input wire logic send_hardline,
  // acquisition status
  output logic host_synced
);
  import cwd_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_PRE, H_DATA} cwd_hstate_type;

  typedef struct packed {
    cwd_hstate_type st;
    logic [1:0] div;
    logic lclk;
    logic [31:0] bcnt;
    logic [31:0] scnt;
    logic synced;
    logic pend;
    logic hard;
    logic [WORD_BITS-1:0] word;
    logic [5:0] idx;
    logic bitval;
    logic bit_end;
    logic wsync;
    logic signed [SAMPLE_W-1:0] integ;
    logic signed [SAMPLE_W-1:0] phase;
  } cwd_host_type;

  cwd_host_type hq, hn;
  logic adv;
  logic [31:0] bit_last;
  logic [31:0] half;
  logic [31:0] bnext;
  logic [31:0] snext;
  logic [31:0] slast;

  assign bit_last = 32'(BIT_LINK_CLKS - 1);
  assign half = 32'(BIT_LINK_CLKS / 2);
  // link fields move when the divided clock falls, two system clocks before its next rise
  assign adv = (hq.div == 2'h0);
  assign bnext = (hq.bcnt == bit_last) ? 32'h0 : hq.bcnt + 32'h1;
  assign slast = hq.synced ? bit_last : bit_last + 32'(SYNC_SLIP);
  assign snext = (hq.scnt >= slast) ? 32'h0 : hq.scnt + 32'h1;
  assign send_ready = (hq.st == H_IDLE) && !hq.pend;

  always_comb begin
    hn = hq;
    hn.div = (hq.div == 2'(LINK_DIV - 1)) ? 2'h0 : hq.div + 2'h1;
    hn.lclk = (hn.div == 2'h0);
    if (send_valid && send_ready) begin
      hn.pend = 1'b1;
      hn.hard = send_hardline;
      hn.word = send_word;
    end
    if (adv) begin
      hn.bcnt = bnext;
      hn.scnt = snext;
      if (bnext == 32'h0 && snext == 32'h0) begin
        hn.synced = 1'b1;
      end
      if (hq.bcnt == bit_last) begin
        unique case (hq.st)
          H_IDLE: begin
            hn.bitval = 1'b0;
            if (hq.pend && hq.hard) begin
              hn.st = H_DATA;
              hn.idx = '0;
              hn.bitval = hq.word[WORD_BITS-1];
            end else if (hq.pend && hq.synced) begin
              hn.st = H_PRE;
              hn.idx = '0;
              hn.bitval = 1'b1;
            end
          end
          H_PRE: begin
            hn.idx = hq.idx + 6'h1;
            if (hq.idx == PRE_LAST) begin
              hn.st = H_DATA;
              hn.idx = '0;
              hn.bitval = hq.word[WORD_BITS-1];
            end
          end
          H_DATA: begin
            hn.idx = hq.idx + 6'h1;
            // the next index is only formed while bits remain, so it never runs below zero
            if (hq.idx == (hq.hard ? HARD_LAST : RADIO_LAST)) begin
              hn.st = H_IDLE;
              hn.pend = 1'b0;
              hn.bitval = 1'b0;
            end else begin
              hn.bitval = hq.word[ID_MSB - 1 - int'(hq.idx)];
            end
          end
          default: begin
            hn.st = H_IDLE;
          end
        endcase
      end
      hn.bit_end = (bnext == bit_last);
      hn.integ = hn.bitval ? -INTEG_MAG : INTEG_MAG;
      hn.phase = ((hn.scnt < half) == (hn.bcnt < half)) ? PHASE_MAG : -PHASE_MAG;
      hn.wsync = (hn.st == H_DATA) && hn.hard && (hn.idx == 6'h0)
        && (hn.bcnt < 32'(PULSE_LINK_CLKS));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hq <= '0;
    end else begin
      hq <= hn;
    end
  end

  // link drive, all registered
  assign link.link_clk = hq.lclk;
  assign link.bit_end = hq.bit_end;
  assign link.integ_sample = hq.integ;
  assign link.phase_sample = hq.phase;
  assign link.sc_lock = hq.synced;
  assign link.hardline = hq.hard;
  assign link.word_sync = hq.wsync;
  assign host_synced = hq.synced;
endmodule

// ==== tb/cwd_link_chk.sv ====
module cwd_link_chk #(
  parameter int BIT_LINK_CLKS = cwd_pkg::BIT_LINK_CLKS_DEF
) (
  // clocks and reset
  input logic clk_sys,
  input logic reset,
  input logic link_clk,
  // link fields
  input logic bit_end,
  input logic signed [cwd_pkg::SAMPLE_W-1:0] integ_sample,
  input logic sc_lock,
  input logic word_sync,
  // decoder outputs
  input logic decoder_power,
  input logic command_done,
  input logic quant_pulse_one,
  input logic quant_pulse_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  import cwd_pkg::*;
  // a bit shorter than the pulse carries the sync for the whole bit
  localparam int SYNC_LEN = (BIT_LINK_CLKS < PULSE_LINK_CLKS) ? BIT_LINK_CLKS : PULSE_LINK_CLKS;
  logic [31:0] bit_cnt_q;
  logic [31:0] sync_cnt_q;
  logic seen_q;
  logic end_q;
  logic [11:0] one_cnt_q;
  logic [11:0] zero_cnt_q;
  logic [5:0] lock_cnt_q;

  // link clocks since the last bit end and length of the sync pulse
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      bit_cnt_q <= '0;
      sync_cnt_q <= '0;
      seen_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_end ? 32'h0 : bit_cnt_q + 32'h1;
      sync_cnt_q <= word_sync ? sync_cnt_q + 32'h1 : 32'h0;
      seen_q <= seen_q | bit_end;
      end_q <= bit_end;
    end
  end

  // pulse lengths, and cycles without lock (saturates so it never wraps)
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      one_cnt_q <= '0;
      zero_cnt_q <= '0;
      lock_cnt_q <= '0;
    end else begin
      one_cnt_q <= quant_pulse_one ? one_cnt_q + 12'h1 : 12'h0;
      zero_cnt_q <= quant_pulse_zero ? zero_cnt_q + 12'h1 : 12'h0;
      lock_cnt_q <= sc_lock ? 6'h00 : ((lock_cnt_q == 6'h3f) ? lock_cnt_q : lock_cnt_q + 6'h01);
    end
  end

  sequence s_sync_fall;
    word_sync ##1 !word_sync;
  endsequence
  property p_sync_len;
    @(posedge link_clk) disable iff (reset) s_sync_fall |-> sync_cnt_q == SYNC_LEN;
  endproperty

  a_bit_period: assert property (@(posedge link_clk) disable iff (reset)
    seen_q && bit_end |-> bit_cnt_q == BIT_LINK_CLKS - 1) else $error("bit length wrong");
  a_bit_end_single: assert property (@(posedge link_clk) disable iff (reset)
    bit_end |=> !bit_end) else $error("bit end longer than one link clock");
  a_integ_hold: assert property (@(posedge link_clk) disable iff (reset)
    seen_q && !end_q |-> $stable(integ_sample)) else $error("integrator sample moved in a bit");
  a_sync_width: assert property (p_sync_len) else $error("word sync width wrong");
  a_pulse_one_width: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(quant_pulse_one) |-> one_cnt_q == PULSE_CYC) else $error("one pulse width wrong");
  a_pulse_zero_width: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(quant_pulse_zero) |-> zero_cnt_q == PULSE_CYC) else $error("zero pulse width wrong");
  a_pulse_excl: assert property (@(posedge clk_sys) disable iff (reset)
    !(quant_pulse_one && quant_pulse_zero)) else $error("both pulse polarities at once");
  a_done_single: assert property (@(posedge clk_sys) disable iff (reset)
    command_done |=> !command_done) else $error("done longer than one cycle");
  a_done_powered: assert property (@(posedge clk_sys) disable iff (reset)
    command_done |-> decoder_power) else $error("command done without power");
  a_lock_loss_off: assert property (@(posedge clk_sys) disable iff (reset)
    lock_cnt_q == 6'h28 |-> !decoder_power) else $error("power kept without lock");
endmodule

// ==== tb/command_word_decoder_test.sv ====
module command_word_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cwd_pkg::*;
  // short bits and a tick just slow enough to keep 10 us pulses apart
  localparam int BIT = 20;
  localparam int TICK = 2100;
  typedef struct packed {
    logic quant;
    logic [DEST_W-1:0] dest;
    logic [QUANT_BITS-1:0] data;
    logic [DIRECT_N-1:0] dir;
  } cwd_note_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic send_valid = 1'b0;
  logic send_ready, host_synced, vco_count_bit, decoder_power, command_done;
  logic [WORD_BITS-1:0] send_word = '0;
  logic send_hardline = 1'b0;
  logic test_active = 1'b0;
  logic vco_tick = 1'b0;
  logic count_gate_start = 1'b0;
  logic count_gate_stop = 1'b0;
  logic frequency_count_shift_pulses = 1'b0;
  logic quant_pulse_one, quant_pulse_zero;
  logic [DIRECT_N-1:0] direct_command;
  logic [DEST_W-1:0] quantitative_command;
  logic [DIRECT_N-1:0] exp_dir = '0;
  logic [QUANT_BITS-1:0] got_bits = '0;
  logic p1_q = 1'b0;
  logic p0_q = 1'b0;
  logic [62:0] w;
  logic [15:0] cnt;
  logic [15:0] got_cnt;
  int fails = 0;
  int samples_checked = 0;
  int seed = 33044;
  cwd_note_type notes[$];
  cwd_link_if link_bus();

  cwd_command_source #(.BIT_LINK_CLKS(BIT), .SYNC_SLIP(1)) u_cwd_command_source (
    .clk_sys(clk_sys), .reset(reset), .link(link_bus), .send_valid(send_valid),
    .send_ready(send_ready), .send_word(send_word), .send_hardline(send_hardline),
    .host_synced(host_synced));
  // test mode borrows the detected sign as its stored word, so the same words check it
  cwd_decoder #(.TICK_CYC(TICK)) u_cwd_decoder (
    .clk_sys(clk_sys), .reset(reset), .link(link_bus), .test_active(test_active),
    .test_bit(link_bus.integ_sample[SAMPLE_W-1]),
    .vco_tick(vco_tick), .count_gate_start(count_gate_start),
    .count_gate_stop(count_gate_stop),
    .frequency_count_shift_pulses(frequency_count_shift_pulses),
    .vco_count_bit(vco_count_bit), .decoder_power(decoder_power),
    .direct_command(direct_command), .quantitative_command(quantitative_command),
    .quant_pulse_one(quant_pulse_one), .quant_pulse_zero(quant_pulse_zero),
    .command_done(command_done));
  cwd_link_chk #(.BIT_LINK_CLKS(BIT)) u_cwd_link_chk (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_bus.link_clk),
    .bit_end(link_bus.bit_end), .integ_sample(link_bus.integ_sample),
    .sc_lock(link_bus.sc_lock), .word_sync(link_bus.word_sync),
    .decoder_power(decoder_power), .command_done(command_done),
    .quant_pulse_one(quant_pulse_one), .quant_pulse_zero(quant_pulse_zero));

  always #2.5 clk_sys = ~clk_sys;

  task conclude;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk_cmd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_count(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // parity of the cyclic code, x^6 + x + 1, bit 1 at the highest degree
  function automatic logic [62:0] encode(input logic [62:0] m);
    logic [5:0] r;
    r = '0;
    for (int i = 62; i >= 6; i--) r = {r[4:0], 1'b0} ^ ((m[i] ^ r[5]) ? GEN_LOW : 6'h00);
    return {m[62:6], r};
  endfunction
  // note the expectation, then hand the word over (held until taken)
  task send_cmd(input logic [62:0] cw, input logic [62:0] sent, input logic hl);
    int n;
    logic rdy;
    n = 0;
    if (cw[62]) notes.push_back({1'b1, cw[61:52], cw[51:20], exp_dir});
    else begin
      exp_dir[cw[55:52]] = cw[56];
      notes.push_back({1'b0, 10'h000, 32'h0, exp_dir});
    end
    @(posedge clk_sys);
    #1 send_word = sent;
    send_hardline = hl;
    send_valid = 1'b1;
    // ready is looked at mid-cycle, where it shows whether the next edge takes the word
    do begin
      @(negedge clk_sys);
      rdy = send_ready;
      @(posedge clk_sys);
      n++;
    end while (rdy !== 1'b1 && n < 400000);
    #1 send_valid = 1'b0;
  endtask
  task wait_idle(input string name);
    int n;
    n = 0;
    while (notes.size() != 0 && n < 400000) begin @(posedge clk_sys); n++; end
    $display("test %s finished", name);
  endtask

  // collect pulse bits and compare when a command completes; mid-cycle, outputs are settled
  always @(negedge clk_sys) begin
    cwd_note_type e;
    if (quant_pulse_one === 1'b1 && !p1_q) got_bits = {got_bits[30:0], 1'b1};
    if (quant_pulse_zero === 1'b1 && !p0_q) got_bits = {got_bits[30:0], 1'b0};
    p1_q = (quant_pulse_one === 1'b1);
    p0_q = (quant_pulse_zero === 1'b1);
    if (command_done === 1'b1) begin
      if (notes.size() == 0) chk_cmd(32'h1, 32'h0);
      else begin
        e = notes.pop_front();
        chk_cmd(32'(direct_command), 32'(e.dir));
        if (e.quant) begin
          chk_cmd(32'(quantitative_command), 32'(e.dest));
          chk_cmd(got_bits, e.data);
        end
      end
    end
  end

  initial begin
    #2_500_000;
    fails++;
    $display("watchdog expired");
    conclude;
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    // frequency counter: gate, count slow edges, shift out MSB first
    cnt = 16'(20 + ($unsigned($random(seed)) % 30));
    @(posedge clk_sys);
    #1 count_gate_start = 1'b1;
    @(posedge clk_sys);
    #1 count_gate_start = 1'b0;
    repeat (cnt) begin
      repeat (4) @(posedge clk_sys);
      #1 vco_tick = ~vco_tick;
      repeat (4) @(posedge clk_sys);
      #1 vco_tick = ~vco_tick;
    end
    repeat (8) @(posedge clk_sys);
    #1 count_gate_stop = 1'b1;
    @(posedge clk_sys);
    #1 count_gate_stop = 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (3) @(posedge clk_sys);
      #1 frequency_count_shift_pulses = 1'b1;
      @(posedge clk_sys);
      #1 frequency_count_shift_pulses = 1'b0;
      repeat (3) @(posedge clk_sys);
      got_cnt = {got_cnt[14:0], vco_count_bit};
    end
    chk_count(got_cnt, cnt);
    $display("test frequency counter finished");
    while (host_synced !== 1'b1) @(posedge clk_sys);
    // hardline quantitative: 43 bits, no correction, 32 pulses
    w = {$random(seed), $random(seed)};
    w[62] = 1'b1;
    send_cmd(w, w, 1'b1);
    wait_idle("hardline quantitative");
    // back-to-back hardline direct commands to random latches, bits through test mode
    @(posedge clk_sys);
    #1 test_active = 1'b1;
    for (int i = 0; i < 4; i++) begin
      w = {$random(seed), $random(seed)};
      w[62] = 1'b0;
      send_cmd(w, w, 1'b1);
    end
    wait_idle("hardline direct");
    @(posedge clk_sys);
    #1 test_active = 1'b0;
    // radio direct command with one flipped bit anywhere in the word
    w = {$random(seed), $random(seed)};
    w[62] = 1'b0;
    w = encode(w);
    send_cmd(w, w ^ (63'h1 << ($unsigned($random(seed)) % 63)), 1'b0);
    wait_idle("radio corrected direct");
    conclude;
  end
endmodule
